// File: rtl/diag_monitor_filter_config.sv
// Filter resistor and diagnostic monitor configuration registers
// What this block does
// - Decode channel 5 filter code to 60R, 5.6k, 11.2k, 22.2k, 44.4k or 104k.
// - Filter select is bits 3:0, read/write, resets to zero (60 ohm).
// - Monitor bits 7:6 choose off, voltage, current or temperature diagnostics.
// - Monitor bit 5 set enables the mux output buffer; clear bypasses it.
// - Monitor bit 4 set turns off internal diode bias; external bias used.
// - Monitor bits 3:0 pick channel 0 to 5 for voltage or current diagnostics.
// - Monitor register sits at 0x23, resets to 0x00, all fields read/write.
`include "diag_consts.svh"
module diag_monitor_filter_config
  import diag_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic rvalid,
  output filt_sel_t ch5_filter_sel,
  output diag_ctrl_t diag_ctrl
);
  localparam int NUM_CHAN = `CHAN_COUNT;
  localparam int FILT_W = `FILT_MSB - `FILT_LSB + 1;
  localparam int CHAN_W = `CHAN_MSB - `CHAN_LSB + 1;

  // Address decode, shared by the write and read paths
  logic filt_hit;
  logic mon_hit;
  logic filt_wr;
  logic mon_wr;
  logic filt_rd;
  logic mon_rd;
  logic unmapped_rd;

  // Filter select register
  logic [FILT_W-1:0] filt_q;
  logic [FILT_W-1:0] filt_d;

  // Monitor setup register
  logic [7:0] mon_q;
  logic [7:0] mon_d;

  // Read return, one group for the strobe and one for the data
  logic [7:0] filt_view;
  logic [7:0] mon_view;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  // Monitor field decode
  diag_func_t func_c;
  logic amp_en_c;
  logic bias_ext_c;
  logic [CHAN_W-1:0] chan_code;
  logic chan_in_range;
  logic chan_routed;
  logic [NUM_CHAN-1:0] chan_hit;

  // Registered monitor controls
  diag_ctrl_t ctrl_q;
  diag_ctrl_t ctrl_d;

  // Filter resistor decode
  filt_sel_t filt_sel_c;
  filt_sel_t filt_sel_q;
  filt_sel_t filt_sel_d;

  // Only one register can match, so a chain keeps the hits exclusive
  always_comb begin
    filt_hit = 1'b0;
    mon_hit = 1'b0;
    if (addr == `CH5_FILTER_ADDR) begin
      filt_hit = 1'b1;
    end else if (addr == `DIAG_SELECT_ADDR) begin
      mon_hit = 1'b1;
    end
  end

  assign filt_wr = wr_en && filt_hit;
  assign mon_wr = wr_en && mon_hit;
  assign filt_rd = rd_en && filt_hit;
  assign mon_rd = rd_en && mon_hit;
  assign unmapped_rd = rd_en && !filt_hit && !mon_hit;

  // Upper nibble of a filter write is reserved and dropped
  always_comb begin
    filt_d = filt_q;
    if (filt_wr) begin
      filt_d = wdata[`FILT_MSB:`FILT_LSB];
    end
  end

  // Any code is kept as written, even one that the decoder leaves open
  always_ff @(posedge clk) begin
    if (srst) begin
      filt_q <= FILT_W'(`CFG_RESET_VAL);
    end else begin
      filt_q <= filt_d;
    end
  end

  // All eight bits are fields, none reserved
  always_comb begin
    mon_d = mon_q;
    if (mon_wr) begin
      mon_d = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mon_q <= `CFG_RESET_VAL;
    end else begin
      mon_q <= mon_d;
    end
  end

  // Reserved filter bits read back as zero
  assign filt_view = 8'(filt_q);
  assign mon_view = mon_q;

  // A read of any address is answered, mapped or not
  always_comb begin
    rvalid_d = rd_en;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
    end
  end

  // Reads see the value held before a same-cycle write; unmapped reads return zero
  always_comb begin
    rdata_d = '0;
    if (filt_rd) begin
      rdata_d = filt_view;
    end else if (mon_rd) begin
      rdata_d = mon_view;
    end else if (unmapped_rd) begin
      rdata_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign func_c = diag_func_t'(mon_q[`FUNC_MSB:`FUNC_LSB]);
  assign amp_en_c = mon_q[`AMP_EN_BIT];
  assign bias_ext_c = mon_q[`BIAS_EXT_BIT];
  assign chan_code = mon_q[`CHAN_MSB:`CHAN_LSB];

  // Codes above the last channel are stored but route nothing
  assign chan_in_range = chan_code <= `CHAN_LAST;
  // Channel routing only matters for voltage and current diagnostics
  assign chan_routed = chan_in_range && (func_c == diag_voltage || func_c == diag_current);

  // One comparator per output channel
  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    assign chan_hit[i] = chan_routed && chan_code == CHAN_W'(i);
  end

  always_comb begin
    ctrl_d = '0;
    ctrl_d.func = func_c;
    ctrl_d.amp_en = amp_en_c;
    ctrl_d.bias_internal_en = ~bias_ext_c;
    ctrl_d.chan_valid = chan_routed;
    ctrl_d.chan_onehot = chan_hit;
  end

  // Reset state equals the decode of an all-zero monitor register
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q.func <= diag_off;
      ctrl_q.amp_en <= 1'b0;
      ctrl_q.bias_internal_en <= 1'b1;
      ctrl_q.chan_valid <= 1'b0;
      ctrl_q.chan_onehot <= '0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Decoder is purely combinational; its output is registered below
  filter_res_decode u_filt (
    .code(filt_q),
    .sel(filt_sel_c)
  );

  always_comb begin
    filt_sel_d = filt_sel_c;
  end

  // Switch selects are registered so the analog side never sees decode glitches
  always_ff @(posedge clk) begin
    if (srst) begin
      filt_sel_q.valid <= 1'b1;
      filt_sel_q.onehot <= `FILT_ONEHOT_RESET;
    end else begin
      filt_sel_q <= filt_sel_d;
    end
  end

  assign rdata = rdata_q;
  assign rvalid = rvalid_q;
  assign ch5_filter_sel = filt_sel_q;
  assign diag_ctrl = ctrl_q;
endmodule : diag_monitor_filter_config

// File: rtl/diag_consts.svh
// Register map constants for the filter and monitor configuration bank
`ifndef DIAG_CONSTS_SVH
`define DIAG_CONSTS_SVH
`define CH5_FILTER_ADDR 8'h22
`define DIAG_SELECT_ADDR 8'h23
`define CFG_RESET_VAL 8'h00
`define FILT_LSB 0
`define FILT_MSB 3
`define FUNC_LSB 6
`define FUNC_MSB 7
`define AMP_EN_BIT 5
`define BIAS_EXT_BIT 4
`define CHAN_LSB 0
`define CHAN_MSB 3
`define FILT_60R 4'h0
`define FILT_5K6 4'h5
`define FILT_11K2 4'h6
`define FILT_22K2 4'h7
`define FILT_44K4 4'h8
`define FILT_104K 4'h9
`define CHAN_LAST 4'h5
`define CHAN_COUNT 6
`define FILT_ONEHOT_RESET 6'h01
`define FUNC_OFF 2'h0
`define FUNC_VOLT 2'h1
`define FUNC_CURR 2'h2
`define FUNC_TEMP 2'h3
`endif

// File: rtl/diag_pkg.sv
// Types shared by the configuration bank
package diag_pkg;
  typedef enum logic [1:0] {
    diag_off,
    diag_voltage,
    diag_current,
    diag_temperature
  } diag_func_t;

  typedef struct packed {
    logic valid;
    logic [5:0] onehot;
  } filt_sel_t;

  typedef struct packed {
    diag_func_t func;
    logic amp_en;
    logic bias_internal_en;
    logic chan_valid;
    logic [5:0] chan_onehot;
  } diag_ctrl_t;
endpackage : diag_pkg

// File: rtl/filter_res_decode.sv
// Decoder from filter select code to one-hot resistor switch enables
`include "diag_consts.svh"
module filter_res_decode
  import diag_pkg::*;
(
  input wire logic [3:0] code,
  output filt_sel_t sel
);
  always_comb begin
    sel = '0;
    // Unlisted codes leave every resistor switch open
    case (code)
      `FILT_60R: sel = '{valid: 1'b1, onehot: 6'h01};
      `FILT_5K6: sel = '{valid: 1'b1, onehot: 6'h02};
      `FILT_11K2: sel = '{valid: 1'b1, onehot: 6'h04};
      `FILT_22K2: sel = '{valid: 1'b1, onehot: 6'h08};
      `FILT_44K4: sel = '{valid: 1'b1, onehot: 6'h10};
      `FILT_104K: sel = '{valid: 1'b1, onehot: 6'h20};
      default: sel = '0;
    endcase
  end
endmodule : filter_res_decode

// File: dv/diag_cfg_checker.sv
// Port checker for the filter and monitor configuration bank
module diag_cfg_checker
  import diag_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input filt_sel_t ch5_filter_sel,
  input diag_ctrl_t diag_ctrl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mon_q, mon_p;
  logic [3:0] flt_q, flt_p;
  logic [5:0] f_e, c_e;
  // Shadows lag one edge because decoded outputs follow the register a cycle later
  always_ff @(posedge clk) begin
    mon_p <= srst ? 8'h00 : mon_q;
    flt_p <= srst ? 4'h0 : flt_q;
    if (srst) begin
      mon_q <= 8'h00;
      flt_q <= 4'h0;
    end else if (wr_en && addr == 8'h23) begin
      mon_q <= wdata;
    end else if (wr_en && addr == 8'h22) begin
      flt_q <= wdata[3:0];
    end
  end
  assign f_e = (flt_p == 4'h0) ? 6'h01 : (flt_p inside {[5:9]}) ? 6'h01 << (flt_p - 4'h4) : 6'h00;
  assign c_e = (mon_p[7:6] inside {2'h1, 2'h2} && mon_p[3:0] < 4'h6) ? 6'h01 << mon_p[3:0] : 6'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence rd_mon; rd_en && addr == 8'h23; endsequence
  chk_filt_decode: assert property (ch5_filter_sel == {f_e != 6'h00, f_e})
    else $error("filter select mismatch");
  chk_func_map: assert property (diag_ctrl.func == mon_p[7:6])
    else $error("monitor function mismatch");
  chk_amp_map: assert property (diag_ctrl.amp_en == mon_p[5])
    else $error("buffer enable mismatch");
  chk_bias_map: assert property (diag_ctrl.bias_internal_en != mon_p[4])
    else $error("diode bias mismatch");
  chk_chan_map: assert property (
    diag_ctrl.chan_onehot == c_e && diag_ctrl.chan_valid == |c_e)
    else $error("monitor channel mismatch");
  chk_rd_mon: assert property (rd_mon |=> rvalid && rdata == $past(mon_q))
    else $error("monitor readback mismatch");
  chk_rd_filt: assert property (
    rd_en && addr == 8'h22 |=> rdata == {4'h0, $past(flt_q)})
    else $error("filter readback mismatch");
  chk_rd_unmap: assert property (
    rd_en && addr > 8'h23 |=> rvalid ##0 rdata == 8'h00)
    else $error("unmapped read mismatch");
endmodule : diag_cfg_checker

// File: dv/tb_top.sv
// Register-level testbench for the configuration bank
`define CK(a, e) begin \
  tests_run++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("unexpected at %0t got %h exp %h", $time, (a), (e)); \
  end \
end
module tb_top
  import diag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, wr_en = 0, rd_en = 0, rvalid;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  filt_sel_t ch5_filter_sel;
  diag_ctrl_t diag_ctrl;
  int fail_count = 0, tests_run = 0;
  always #2 clk = ~clk;
  diag_monitor_filter_config diag_monitor_filter_config_i (.clk(clk), .srst(srst), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
    .ch5_filter_sel(ch5_filter_sel), .diag_ctrl(diag_ctrl));
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    {wr_en, addr, wdata} = {1'b1, a, d};
    @(negedge clk);
    wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk);
    {rd_en, addr} = {1'b1, a};
    @(negedge clk);
    rd_en = 1'b0;
    `CK({rvalid, rdata}, {1'b1, e})
  endtask : rd
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  // Whole run is under two hundred cycles, so this only trips on a hang
  initial begin
    #20000;
    fail_count++;
    close_out();
  end
  initial begin
    repeat (20) @(negedge clk);
    srst = 1'b0;
    rd(8'h22, 8'h00);
    rd(8'h23, 8'h00);
    `CK({ch5_filter_sel, diag_ctrl}, {7'h41, 11'h080})
    @(negedge clk);
    `CK({rvalid, rdata}, 9'h000)
    $display("reset test done");
    for (int c = 0; c < 16; c++) begin
      wr(8'h22, {4'hF, 4'(c)});
      rd(8'h22, {4'h0, 4'(c)});
      `CK(ch5_filter_sel.valid, c == 0 || (c > 4 && c < 10))
    end
    $display("filter test done");
    for (int k = 0; k < 16; k++) begin
      wr(8'h23, 8'(k * 17));
      rd(8'h23, 8'(k * 17));
      `CK(diag_ctrl.func, diag_func_t'(k[3:2]))
      `CK({diag_ctrl.amp_en, diag_ctrl.bias_internal_en}, {k[1], ~k[0]})
      `CK(diag_ctrl.chan_valid, k == 4 || k == 5)
    end
    $display("monitor test done");
    wr(8'h24, 8'hAA);
    rd(8'h24, 8'h00);
    rd(8'h23, 8'hFF);
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    rd(8'h23, 8'h00);
    rd(8'h22, 8'h00);
    `CK({ch5_filter_sel, diag_ctrl}, {7'h41, 11'h080})
    $display("unmapped and reset test done");
    close_out();
  end
endmodule : tb_top
bind diag_monitor_filter_config diag_cfg_checker diag_cfg_checker_i (.clk(clk), .srst(srst),
  .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
  .ch5_filter_sel(ch5_filter_sel), .diag_ctrl(diag_ctrl));
